// File: rtl/module_disable_pkg.sv
// shared constants for the peripheral module-disable register bank
package module_disable_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned NREG   = 7;

  // byte offsets of the disable registers (one 32-bit word each)
  localparam logic [4:0] OFF_MD1 = 5'h00;
  localparam logic [4:0] OFF_MD2 = 5'h04;
  localparam logic [4:0] OFF_MD3 = 5'h08;
  localparam logic [4:0] OFF_MD4 = 5'h0C;
  localparam logic [4:0] OFF_MD6 = 5'h10;
  localparam logic [4:0] OFF_MD7 = 5'h14;
  localparam logic [4:0] OFF_MD8 = 5'h18;

  // implemented-bit masks
  localparam logic [15:0] MASK_MD1 = 16'h0EFB;
  localparam logic [15:0] MASK_MD2 = 16'h01FF;
  localparam logic [15:0] MASK_MD3 = 16'h01AE;
  localparam logic [15:0] MASK_MD4 = 16'h0008;
  localparam logic [15:0] MASK_MD6 = 16'h0F01;
  localparam logic [15:0] MASK_MD7 = 16'h0708;
  localparam logic [15:0] MASK_MD8 = 16'h393E;

  localparam logic [15:0] RST_MD = 16'h0000;

  // register 1 fields
  localparam int unsigned B_TIMER1  = 11;
  localparam int unsigned B_QEI1    = 10;
  localparam int unsigned B_PWM     = 9;
  localparam int unsigned B_I2C1    = 7;
  localparam int unsigned B_UART2   = 6;
  localparam int unsigned B_UART1   = 5;
  localparam int unsigned B_SPI2    = 4;
  localparam int unsigned B_SPI1    = 3;
  localparam int unsigned B_CAN1    = 1;
  localparam int unsigned B_ADC     = 0;
  // register 2: capture/compare units 1..9 at bits 0..8
  localparam int unsigned B_CCP1    = 0;
  // register 3
  localparam int unsigned B_PMP     = 8;
  localparam int unsigned B_CRC     = 7;
  localparam int unsigned B_QEI2    = 5;
  localparam int unsigned B_UART3   = 3;
  localparam int unsigned B_I2C3    = 2;
  localparam int unsigned B_I2C2    = 1;
  // register 4
  localparam int unsigned B_REFO    = 3;
  // register 6: dma channels 0..3 at bits 8..11
  localparam int unsigned B_DMA0    = 8;
  localparam int unsigned B_SPI3    = 0;
  // register 7
  localparam int unsigned B_CMP1    = 8;
  localparam int unsigned B_PTG     = 3;
  // register 8
  localparam int unsigned B_OPAMP   = 13;
  localparam int unsigned B_SENT2   = 12;
  localparam int unsigned B_SENT1   = 11;
  localparam int unsigned B_DMT     = 8;
  localparam int unsigned B_CLC1    = 2;
  localparam int unsigned B_BIAS    = 1;

  // change reaches the module one instruction cycle after the write
  localparam int unsigned INSTR_CYCLE_NS = 8;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned APPLY_CYCLES   =
    (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: rtl/module_disable_bank.sv
// peripheral module-disable register bank with glitch-free clock-gate enables
//
// How it works
// - bit one disables module, zero enables it
// - unimplemented bits read zero, writes ignored
// - reg1 bits 11,10,9: timer1, quad1, pwm
// - reg1 bits 7..3: i2c1,uart2,uart1,spi2,spi1
// - reg1 bit1 can1, bit0 adc
// - reg2 bit8 capture/compare unit 9
// - reg2 bits 7..0 capture/compare 8..1
// - reg3 bit8 parallel master port
// - reg3 bit7 crc, bit6 unimplemented
// - reg3 bit5 quad decoder 2
// - reg3 bits 3,2,1: uart3,i2c3,i2c2
// - reg4 only bit3, reference clock output
// - reg6 bits 11..8 dma channels 3..0
// - reg6 bit0 spi3, others unimplemented
// - reg7 bits 10,9,8 comparators 3,2,1
// - reg7 bit3 trigger generator
// - reg8 bit13 disables all op amps
// - reg8 bits 12,11 sent 2,1
// - reg8 bit8 deadman timer
// - reg8 bit1 current source, bit0 unimplemented
// - disabled module's clocks all stopped
// - change takes effect one instruction cycle later
// - reg1 and reg3 modules get a run enable, set only if enabled and present
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps

module module_disable_bank #(
  parameter logic [15:0] PRESENT_MD1 = 16'hFFFF,
  parameter logic [15:0] PRESENT_MD3 = 16'hFFFF
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [1:0]  avs_response_o,
  output logic             timer1_off_o,
  output logic             quad_decoder1_off_o,
  output logic             pwm_block_off_o,
  output logic             i2c_port1_off_o,
  output logic             uart_port2_off_o,
  output logic             uart_port1_off_o,
  output logic             spi_port2_off_o,
  output logic             spi_port1_off_o,
  output logic             can_port1_off_o,
  output logic             adc_block_off_o,
  output logic      [8:0]  capcomp_off_o,
  output logic             parallel_port_off_o,
  output logic             crc_block_off_o,
  output logic             quad_decoder2_off_o,
  output logic             uart_port3_off_o,
  output logic             i2c_port3_off_o,
  output logic             i2c_port2_off_o,
  output logic             ref_clock_out_off_o,
  output logic      [3:0]  dma_chan_off_o,
  output logic             spi_port3_off_o,
  output logic      [2:0]  comparator_off_o,
  output logic             trigger_gen_off_o,
  output logic             op_amps_off_o,
  output logic             sent_port2_off_o,
  output logic             sent_port1_off_o,
  output logic             deadman_timer_off_o,
  output logic      [3:0]  logic_cell_off_o,
  output logic             current_source_off_o,
  output logic      [15:0] module_run_md1_o,
  output logic      [15:0] module_run_md3_o
);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  bus_state_t  bus_reg;
  logic [15:0] md_reg   [module_disable_pkg::NREG];
  logic [15:0] md_mask  [module_disable_pkg::NREG];
  logic [15:0] wr_val;
  logic [15:0] rd_val;
  logic [module_disable_pkg::NREG-1:0] wr_en;
  logic [2:0]  sel;
  logic        sel_hit;
  logic        req;

  assign md_mask[0] = module_disable_pkg::MASK_MD1;
  assign md_mask[1] = module_disable_pkg::MASK_MD2;
  assign md_mask[2] = module_disable_pkg::MASK_MD3;
  assign md_mask[3] = module_disable_pkg::MASK_MD4;
  assign md_mask[4] = module_disable_pkg::MASK_MD6;
  assign md_mask[5] = module_disable_pkg::MASK_MD7;
  assign md_mask[6] = module_disable_pkg::MASK_MD8;

  // address decode
  always_comb begin
    sel_hit = 1'b1;
    if (avs_address_i == module_disable_pkg::OFF_MD1) begin
      sel = 3'h0;
    end else if (avs_address_i == module_disable_pkg::OFF_MD2) begin
      sel = 3'h1;
    end else if (avs_address_i == module_disable_pkg::OFF_MD3) begin
      sel = 3'h2;
    end else if (avs_address_i == module_disable_pkg::OFF_MD4) begin
      sel = 3'h3;
    end else if (avs_address_i == module_disable_pkg::OFF_MD6) begin
      sel = 3'h4;
    end else if (avs_address_i == module_disable_pkg::OFF_MD7) begin
      sel = 3'h5;
    end else if (avs_address_i == module_disable_pkg::OFF_MD8) begin
      sel = 3'h6;
    end else begin
      sel     = 3'h0;
      sel_hit = 1'b0;
    end
  end

  assign req = (avs_read_i | avs_write_i) & (bus_reg == BUS_IDLE);

  // byte-lane merge; only implemented bits take the written value
  always_comb begin
    wr_val = md_reg[sel];
    if (avs_byteenable_i[0]) begin
      wr_val[7:0] = avs_writedata_i[7:0];
    end
    if (avs_byteenable_i[1]) begin
      wr_val[15:8] = avs_writedata_i[15:8];
    end
    wr_val = wr_val & md_mask[sel];
  end

  // read value of the addressed register, implemented bits only
  always_comb begin
    rd_val = 16'h0000;
    if (avs_read_i && sel_hit) begin
      rd_val = md_reg[sel] & md_mask[sel];
    end
  end

  // bus sequencer: one answer cycle follows every taken request
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_reg <= BUS_IDLE;
    end else begin
      case (bus_reg)
        BUS_IDLE: begin
          if (req) begin
            bus_reg <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_reg <= BUS_IDLE;
        end
        default: begin
          bus_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // waitrequest is low only in the answer cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~req;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_response_o <= 2'h0;
    end else if (req && !sel_hit) begin
      avs_response_o <= 2'h3;
    end else begin
      avs_response_o <= 2'h0;
    end
  end

  // read data keep their value after the answer cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (req) begin
      avs_readdata_o <= {16'h0000, rd_val};
    end
  end

  // register file; write lands at the edge that issues the answer
  generate
    for (genvar g = 0; g < module_disable_pkg::NREG; g++) begin : g_md
      assign wr_en[g] = req & avs_write_i & sel_hit & (sel == 3'(g));
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          md_reg[g] <= module_disable_pkg::RST_MD;
        end else if (wr_en[g]) begin
          md_reg[g] <= wr_val;
        end
      end
    end
  endgenerate

  // outputs registered once more: visible one cycle after the write,
  // and as flop outputs they feed latch-based clock gates without runts
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer1_off_o        <= 1'b0;
      quad_decoder1_off_o <= 1'b0;
      pwm_block_off_o     <= 1'b0;
    end else begin
      timer1_off_o        <= md_reg[0][module_disable_pkg::B_TIMER1];
      quad_decoder1_off_o <= md_reg[0][module_disable_pkg::B_QEI1];
      pwm_block_off_o     <= md_reg[0][module_disable_pkg::B_PWM];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      i2c_port1_off_o  <= 1'b0;
      uart_port2_off_o <= 1'b0;
      uart_port1_off_o <= 1'b0;
      spi_port2_off_o  <= 1'b0;
      spi_port1_off_o  <= 1'b0;
    end else begin
      i2c_port1_off_o  <= md_reg[0][module_disable_pkg::B_I2C1];
      uart_port2_off_o <= md_reg[0][module_disable_pkg::B_UART2];
      uart_port1_off_o <= md_reg[0][module_disable_pkg::B_UART1];
      spi_port2_off_o  <= md_reg[0][module_disable_pkg::B_SPI2];
      spi_port1_off_o  <= md_reg[0][module_disable_pkg::B_SPI1];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      can_port1_off_o <= 1'b0;
      adc_block_off_o <= 1'b0;
    end else begin
      can_port1_off_o <= md_reg[0][module_disable_pkg::B_CAN1];
      adc_block_off_o <= md_reg[0][module_disable_pkg::B_ADC];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capcomp_off_o <= 9'h000;
    end else begin
      capcomp_off_o <= md_reg[1][module_disable_pkg::B_CCP1 +: 9];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      parallel_port_off_o <= 1'b0;
      crc_block_off_o     <= 1'b0;
      quad_decoder2_off_o <= 1'b0;
    end else begin
      parallel_port_off_o <= md_reg[2][module_disable_pkg::B_PMP];
      crc_block_off_o     <= md_reg[2][module_disable_pkg::B_CRC];
      quad_decoder2_off_o <= md_reg[2][module_disable_pkg::B_QEI2];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uart_port3_off_o <= 1'b0;
      i2c_port3_off_o  <= 1'b0;
      i2c_port2_off_o  <= 1'b0;
    end else begin
      uart_port3_off_o <= md_reg[2][module_disable_pkg::B_UART3];
      i2c_port3_off_o  <= md_reg[2][module_disable_pkg::B_I2C3];
      i2c_port2_off_o  <= md_reg[2][module_disable_pkg::B_I2C2];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_clock_out_off_o <= 1'b0;
    end else begin
      ref_clock_out_off_o <= md_reg[3][module_disable_pkg::B_REFO];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dma_chan_off_o <= 4'h0;
    end else begin
      dma_chan_off_o <= md_reg[4][module_disable_pkg::B_DMA0 +: 4];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      spi_port3_off_o <= 1'b0;
    end else begin
      spi_port3_off_o <= md_reg[4][module_disable_pkg::B_SPI3];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comparator_off_o <= 3'h0;
    end else begin
      comparator_off_o <= md_reg[5][module_disable_pkg::B_CMP1 +: 3];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trigger_gen_off_o <= 1'b0;
    end else begin
      trigger_gen_off_o <= md_reg[5][module_disable_pkg::B_PTG];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_amps_off_o    <= 1'b0;
      sent_port2_off_o <= 1'b0;
      sent_port1_off_o <= 1'b0;
    end else begin
      op_amps_off_o    <= md_reg[6][module_disable_pkg::B_OPAMP];
      sent_port2_off_o <= md_reg[6][module_disable_pkg::B_SENT2];
      sent_port1_off_o <= md_reg[6][module_disable_pkg::B_SENT1];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      deadman_timer_off_o <= 1'b0;
    end else begin
      deadman_timer_off_o <= md_reg[6][module_disable_pkg::B_DMT];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      logic_cell_off_o     <= 4'h0;
      current_source_off_o <= 1'b0;
    end else begin
      logic_cell_off_o     <= md_reg[6][module_disable_pkg::B_CLC1 +: 4];
      current_source_off_o <= md_reg[6][module_disable_pkg::B_BIAS];
    end
  end

  // run enables combine presence with the disable bit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      module_run_md1_o <= 16'h0000;
    end else begin
      module_run_md1_o <= PRESENT_MD1 & module_disable_pkg::MASK_MD1 & ~md_reg[0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      module_run_md3_o <= 16'h0000;
    end else begin
      module_run_md3_o <= PRESENT_MD3 & module_disable_pkg::MASK_MD3 & ~md_reg[2];
    end
  end

endmodule // module_disable_bank

// File: sim/module_disable_bank_assertions.sv
// port-level assertions for the module-disable register bank
`timescale 1ns/10ps
module module_disable_bank_assertions (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  avs_response_o,
  input wire logic        ref_clock_out_off_o,
  input wire logic        op_amps_off_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // implemented bits per address, zero where nothing is mapped
  function automatic logic [15:0] mask_of(input logic [4:0] a);
    case (a)
      module_disable_pkg::OFF_MD1: return module_disable_pkg::MASK_MD1;
      module_disable_pkg::OFF_MD2: return module_disable_pkg::MASK_MD2;
      module_disable_pkg::OFF_MD3: return module_disable_pkg::MASK_MD3;
      module_disable_pkg::OFF_MD4: return module_disable_pkg::MASK_MD4;
      module_disable_pkg::OFF_MD6: return module_disable_pkg::MASK_MD6;
      module_disable_pkg::OFF_MD7: return module_disable_pkg::MASK_MD7;
      module_disable_pkg::OFF_MD8: return module_disable_pkg::MASK_MD8;
      default: return 16'h0000;
    endcase
  endfunction
  a_answer_next: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered in the next cycle");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer cycle longer than one cycle");
  a_upper_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_unimpl_zero: assert property (!avs_waitrequest_o && $past(avs_read_i)
    |-> (avs_readdata_o[15:0] & ~mask_of($past(avs_address_i))) == 16'h0000)
    else $error("unimplemented bit read as one");
  a_decode_resp: assert property (!avs_waitrequest_o
    |-> avs_response_o == ((mask_of($past(avs_address_i)) == 16'h0000) ? 2'b11 : 2'b00))
    else $error("wrong response code");
  a_refclk_follow: assert property (!avs_waitrequest_o && $past(avs_write_i) && $past(avs_byteenable_i[0])
    && $past(avs_address_i) == module_disable_pkg::OFF_MD4
    |=> ref_clock_out_off_o == $past(avs_writedata_i[3], 2))
    else $error("reference clock disable did not follow write");
  a_opamp_lane: assert property (!avs_waitrequest_o && $past(avs_write_i)
    && $past(avs_address_i) == module_disable_pkg::OFF_MD8
    |=> op_amps_off_o == ($past(avs_byteenable_i[1], 2) ? $past(avs_writedata_i[13], 2) : $past(op_amps_off_o)))
    else $error("op amp disable wrong after write");
  a_off_hold: assert property ($changed(op_amps_off_o) |-> $past(!avs_waitrequest_o) && $past(avs_write_i, 2))
    else $error("op amp disable changed without a write");
endmodule // module_disable_bank_assertions

bind module_disable_bank module_disable_bank_assertions u_chk (.clk_i, .resetn_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
  .ref_clock_out_off_o, .op_amps_off_o);

// File: sim/testbench.sv
// self-checking bench for the module-disable register bank
`timescale 1ns/10ps
module testbench;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o, rd;
  logic [1:0]  avs_response_o, rsp;
  logic        avs_waitrequest_o, timer1_off_o, quad_decoder1_off_o, pwm_block_off_o, i2c_port1_off_o;
  logic        uart_port2_off_o, uart_port1_off_o, spi_port2_off_o, spi_port1_off_o, can_port1_off_o;
  logic        adc_block_off_o, parallel_port_off_o, crc_block_off_o, quad_decoder2_off_o, uart_port3_off_o;
  logic        i2c_port3_off_o, i2c_port2_off_o, ref_clock_out_off_o, spi_port3_off_o, trigger_gen_off_o;
  logic        op_amps_off_o, sent_port2_off_o, sent_port1_off_o, deadman_timer_off_o, current_source_off_o;
  logic [8:0]  capcomp_off_o;
  logic [3:0]  dma_chan_off_o, logic_cell_off_o;
  logic [2:0]  comparator_off_o;
  logic [15:0] module_run_md1_o, module_run_md3_o;
  logic [15:0] r [7];
  logic [15:0] msk [7];
  logic [4:0]  offs [7];
  logic [43:0] got;
  int          fails = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #4 clk_i = ~clk_i;

  module_disable_bank dut (.clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .timer1_off_o, .quad_decoder1_off_o,
    .pwm_block_off_o, .i2c_port1_off_o, .uart_port2_off_o, .uart_port1_off_o, .spi_port2_off_o, .spi_port1_off_o,
    .can_port1_off_o, .adc_block_off_o, .capcomp_off_o, .parallel_port_off_o, .crc_block_off_o,
    .quad_decoder2_off_o, .uart_port3_off_o, .i2c_port3_off_o, .i2c_port2_off_o, .ref_clock_out_off_o,
    .dma_chan_off_o, .spi_port3_off_o, .comparator_off_o, .trigger_gen_off_o, .op_amps_off_o, .sent_port2_off_o,
    .sent_port1_off_o, .deadman_timer_off_o, .logic_cell_off_o, .current_source_off_o, .module_run_md1_o,
    .module_run_md3_o);

  assign got = {timer1_off_o, quad_decoder1_off_o, pwm_block_off_o, i2c_port1_off_o, uart_port2_off_o,
    uart_port1_off_o, spi_port2_off_o, spi_port1_off_o, can_port1_off_o, adc_block_off_o, capcomp_off_o,
    parallel_port_off_o, crc_block_off_o, quad_decoder2_off_o, uart_port3_off_o, i2c_port3_off_o, i2c_port2_off_o,
    ref_clock_out_off_o, dma_chan_off_o, spi_port3_off_o, comparator_off_o, trigger_gen_off_o, op_amps_off_o,
    sent_port2_off_o, sent_port1_off_o, deadman_timer_off_o, logic_cell_off_o, current_source_off_o};

  function automatic logic [43:0] exp_off();
    return {r[0][11:9], r[0][7:3], r[0][1:0], r[1][8:0], r[2][8:7], r[2][5], r[2][3:1], r[3][3],
            r[4][11:8], r[4][0], r[5][10:8], r[5][3], r[6][13:11], r[6][8], r[6][5:1]};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [43:0] g, input logic [43:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= {16'hA5C3, d};
    avs_byteenable_i <= be;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    rsp = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 20) check(44'h1, 44'h0);
  endtask

  // write one register and update the expected image lane by lane
  task automatic wr_reg(input int i, input logic [15:0] d, input logic [3:0] be);
    logic [15:0] lm;
    lm = {{8{be[1]}}, {8{be[0]}}};
    bus(1'b1, offs[i], d, be);
    r[i] = (r[i] & ~lm) | (d & lm & msk[i]);
  endtask

  task automatic t_readall();
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, offs[i], 16'h0000, 4'hF);
      check(44'(rd), 44'(r[i]));
      check(44'(rsp), 44'h0);
    end
    check(got, exp_off());
    check(44'(module_run_md1_o), 44'(module_disable_pkg::MASK_MD1 & ~r[0]));
    check(44'(module_run_md3_o), 44'(module_disable_pkg::MASK_MD3 & ~r[2]));
    $display("register readback test done");
  endtask

  task automatic t_walk();
    for (int i = 0; i < 7; i++) begin
      for (int b = 0; b < 16; b++) begin
        wr_reg(i, 16'h0001 << b, 4'h3);
        bus(1'b0, offs[i], 16'h0000, 4'h3);
        check(44'(rd), 44'(r[i]));
        check(got, exp_off());
      end
      wr_reg(i, 16'h0000, 4'h3);
    end
    $display("walking bit test done");
  endtask

  task automatic t_lanes();
    wr_reg(6, 16'hFFFF, 4'h2);
    wr_reg(6, 16'h0000, 4'h1);
    wr_reg(6, 16'h0000, 4'hC);
    t_readall();
    $display("byte lane test done");
  endtask

  task automatic t_decode();
    wr_reg(3, 16'hFFFF, 4'h3);
    bus(1'b1, 5'h1C, 16'hFFFF, 4'h3);
    check(44'(rsp), 44'h3);
    bus(1'b0, 5'h1C, 16'h0000, 4'h3);
    check(44'(rd), 44'h0);
    check(44'(rsp), 44'h3);
    t_readall();
    $display("unmapped address test done");
  endtask

  task automatic t_midreset();
    for (int i = 0; i < 7; i++) wr_reg(i, 16'hFFFF, 4'h3);
    @(posedge clk_i);
    check(got, exp_off());
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(got, 44'h0);
    resetn_i <= 1'b1;
    for (int i = 0; i < 7; i++) r[i] = 16'h0000;
    t_readall();
    $display("mid-run reset test done");
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    offs = '{module_disable_pkg::OFF_MD1, module_disable_pkg::OFF_MD2, module_disable_pkg::OFF_MD3,
             module_disable_pkg::OFF_MD4, module_disable_pkg::OFF_MD6, module_disable_pkg::OFF_MD7,
             module_disable_pkg::OFF_MD8};
    msk = '{module_disable_pkg::MASK_MD1, module_disable_pkg::MASK_MD2, module_disable_pkg::MASK_MD3,
            module_disable_pkg::MASK_MD4, module_disable_pkg::MASK_MD6, module_disable_pkg::MASK_MD7,
            module_disable_pkg::MASK_MD8};
    for (int i = 0; i < 7; i++) r[i] = 16'h0000;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_readall();
    t_walk();
    t_lanes();
    t_decode();
    t_midreset();
    stop_test();
  end
endmodule // testbench
